// File: src/ppp_map.svh
// constants of the parallel programming port
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH
`define PPP_ACT_ADDR      2'b00
`define PPP_ACT_DATA      2'b01
`define PPP_ACT_CMD       2'b10
`define PPP_CMD_ERASE     8'h80
`define PPP_CMD_WR_FUSE   8'h40
`define PPP_CMD_WR_LOCK   8'h20
`define PPP_CMD_WR_FLASH  8'h10
`define PPP_CMD_WR_EE     8'h11
`define PPP_CMD_RD_SIG    8'h08
`define PPP_CMD_RD_LOCKF  8'h04
`define PPP_CMD_RD_FLASH  8'h02
`define PPP_CMD_RD_EE     8'h03
`define PPP_ERASED        8'hFF
`define PPP_BIT_SDL_FUSE  5
`define PPP_BIT_SHORT     0
`define PPP_BIT_PB2_WR    2
`define PPP_BIT_PB1_WR    1
`define PPP_BIT_PB1_RD    7
`define PPP_BIT_PB2_RD    6
`define PPP_CLK_HZ        10_000_000
`define PPP_BUSY_NS       700_000
`define PPP_SETTLE_NS     100
`define PPP_SIG_LAST      8'h02
`endif

// File: src/ppp_pkg.sv
// types of the parallel programming port
package ppp_pkg;
    typedef struct packed {
        logic [1:0] action;
        logic       half;
        logic [7:0] data;
    } ppp_latch_t;
    typedef enum logic [1:0] {PPP_IDLE, PPP_LOCKED, PPP_ACTIVE} ppp_mode_t;
endpackage

// File: src/ppp_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module ppp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    // first stage is read only by the second
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: src/ppp_port.sv
// parallel programming port: strobe decode, memories, protection, data bus
// Overview of operation
// - strobe pulse acts on action bits: address, data, command or nothing
// - command byte decodes to erase, writes and reads of each space
// - byte-half select picks low or high byte for address, data, read
// - ready/busy low while a byte programs, high when ready
// - data bus driven only while output enable is low
// - entry refused if half-select moves within 100 ns of high voltage
// - erase clears flash, eeprom, then protection; fuses untouched
// - erase runs on write pulse, no ready/busy transition
// - write pulse under flash/eeprom write programs byte, pulls busy low
// - command and address kept across operations
// - flash word address is high byte with low byte
// - flash read gives low byte at select 0, high at 1
// - eeprom read shows addressed byte at select 0
// - fuse write: bit5 serial fuse, bit0 short startup, no busy
// - protection write: bit2 second bit, bit1 first bit, 0 programs
// - protection/fuse read: bit7, bit6, bit5, bit0 at select 1
// - signature read picks id byte by low address zero to two
// - first protection bit blocks flash, eeprom and fuse writes; both also block flash and eeprom reads
// - byte write holds busy low about 0.7 ms after write pulse
`timescale 1ns/10ps
`default_nettype none
`include "ppp_map.svh"
module ppp_port
    import ppp_pkg::*;
#(
    parameter int FLASH_AW  = 12,
    parameter int EE_AW     = 9,
    parameter int BUSY_CYC  = (`PPP_BUSY_NS / 1000) * (`PPP_CLK_HZ / 1_000_000),
    parameter logic [7:0] SIG0 = 8'hA5, // arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h5A, // arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h3C  // arbitrary identity value
) (
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       prog_voltage_i,
    input  wire logic       crystal_strobe_pin_i,
    input  wire logic       strobe_action_bit0_i,
    input  wire logic       strobe_action_bit1_i,
    input  wire logic       byte_half_select_i,
    input  wire logic       write_n_i,
    input  wire logic       output_enable_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic            ready_busy_out_o,
    output logic            prog_mode_o,
    output logic            serial_download_fuse_o,
    output logic            short_startup_fuse_o
);
    import ppp_pkg::*;

    localparam int SETTLE_CYC = (`PPP_SETTLE_NS * (`PPP_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ERASE_W = FLASH_AW > EE_AW ? FLASH_AW : EE_AW;

    // all pins cross into the core clock first
    logic [13:0] pin_s;
    ppp_sync #(.W(14)) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    ({prog_voltage_i, crystal_strobe_pin_i, strobe_action_bit1_i,
                      strobe_action_bit0_i, byte_half_select_i, write_n_i,
                      output_enable_n_i, data_i[6:0]}),
        .sync_o     (pin_s)
    );
    logic       d7_meta_r;
    logic       d7_s_r;
    logic       hv_s;
    logic       xs_s;
    logic       half_s;
    logic       wr_n_s;
    logic       oe_n_s;
    ppp_latch_t lat;
    assign hv_s   = pin_s[13];
    assign xs_s   = pin_s[12];
    assign half_s = pin_s[9];
    assign wr_n_s = pin_s[8];
    assign oe_n_s = pin_s[7];
    assign lat    = '{action: pin_s[11:10], half: pin_s[9], data: {d7_s_r, pin_s[6:0]}};

    // top data bit kept on its own pair to keep the bundle narrow
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            d7_meta_r <= 1'b0;
            d7_s_r    <= 1'b0;
        end else begin
            d7_meta_r <= data_i[7];
            d7_s_r    <= d7_meta_r;
        end
    end

    // edge history for exactly-once actions
    logic xs_d_r;
    logic wr_d_r;
    logic hv_d_r;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            xs_d_r <= 1'b0;
            wr_d_r <= 1'b1;
            hv_d_r <= 1'b0;
        end else begin
            xs_d_r <= xs_s;
            wr_d_r <= wr_n_s;
            hv_d_r <= hv_s;
        end
    end
    logic xs_rise;
    logic wr_fall;
    logic wr_rise;
    assign xs_rise = xs_s & ~xs_d_r;
    assign wr_fall = wr_d_r & ~wr_n_s;
    assign wr_rise = ~wr_d_r & wr_n_s;

    // entry: watch half-select for a short window after high voltage
    ppp_mode_t mode_r;
    logic [7:0] settle_r;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_r   <= PPP_IDLE;
            settle_r <= 8'h00;
        end else if (!hv_s) begin
            mode_r   <= PPP_IDLE;
            settle_r <= 8'h00;
        end else begin
            unique case (mode_r)
                PPP_IDLE: begin
                    if (!hv_d_r) begin
                        settle_r <= 8'(SETTLE_CYC);
                        mode_r   <= half_s ? PPP_LOCKED : PPP_ACTIVE;
                    end
                end
                PPP_ACTIVE: begin
                    if (settle_r != 8'h00) begin
                        settle_r <= settle_r - 8'h01;
                        if (half_s) begin
                            mode_r <= PPP_LOCKED;
                        end
                    end
                end
                PPP_LOCKED: begin
                    mode_r <= PPP_LOCKED;
                end
            endcase
        end
    end
    logic active;
    assign active = (mode_r == PPP_ACTIVE);

    // command, address and data latches, kept until reloaded
    logic [7:0] cmd_r;
    logic [7:0] addr_lo_r;
    logic [7:0] addr_hi_r;
    logic [7:0] dat_lo_r;
    logic [7:0] dat_hi_r;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_r     <= 8'h00;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            dat_lo_r  <= 8'h00;
            dat_hi_r  <= 8'h00;
        end else if (active && xs_rise) begin
            unique case (lat.action)
                `PPP_ACT_ADDR: begin
                    if (lat.half) addr_hi_r <= lat.data;
                    else          addr_lo_r <= lat.data;
                end
                `PPP_ACT_DATA: begin
                    if (lat.half) dat_hi_r <= lat.data;
                    else          dat_lo_r <= lat.data;
                end
                `PPP_ACT_CMD:  cmd_r <= lat.data;
                default: ;                                  // idle action
            endcase
        end
    end

    // flash word and eeprom byte addresses
    logic [FLASH_AW-1:0] faddr;
    logic [EE_AW-1:0]    eaddr;
    assign faddr = FLASH_AW'({addr_hi_r, addr_lo_r});
    assign eaddr = EE_AW'({addr_hi_r, addr_lo_r});

    // storage in flip-flops; erased state is all ones
    logic [7:0] flash_lo_r [2**FLASH_AW];
    logic [7:0] flash_hi_r [2**FLASH_AW];
    logic [7:0] ee_r       [2**EE_AW];
    logic       pb1_r;
    logic       pb2_r;
    logic       sdl_r;
    logic       short_r;

    // decoded write commands; flash, eeprom and fuse writes gated by protection
    logic wr_flash;
    logic wr_ee;
    logic wr_fuse;
    logic wr_lock;
    logic wr_erase;
    assign wr_flash = active && wr_fall && cmd_r == `PPP_CMD_WR_FLASH && pb1_r;
    assign wr_ee    = active && wr_fall && cmd_r == `PPP_CMD_WR_EE && pb1_r && !half_s;
    assign wr_fuse  = active && wr_rise && cmd_r == `PPP_CMD_WR_FUSE && pb1_r;
    assign wr_lock  = active && wr_fall && cmd_r == `PPP_CMD_WR_LOCK && !half_s;
    assign wr_erase = active && wr_fall && cmd_r == `PPP_CMD_ERASE;

    // erase walks every address; protection is released at the end
    logic              erasing_r;
    logic [ERASE_W:0]  ecnt_r;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            erasing_r <= 1'b0;
            ecnt_r    <= '0;
        end else if (wr_erase && !erasing_r) begin
            erasing_r <= 1'b1;
            ecnt_r    <= '0;
        end else if (erasing_r) begin
            ecnt_r <= ecnt_r + 1'b1;
            if (ecnt_r[ERASE_W]) erasing_r <= 1'b0;
        end
    end

    // memory array updates
    always_ff @(posedge core_clk_i) begin
        if (erasing_r && !ecnt_r[ERASE_W]) begin
            if (ecnt_r < (ERASE_W+1)'(2**FLASH_AW)) begin
                flash_lo_r[ecnt_r[FLASH_AW-1:0]] <= `PPP_ERASED;
                flash_hi_r[ecnt_r[FLASH_AW-1:0]] <= `PPP_ERASED;
            end
            if (ecnt_r < (ERASE_W+1)'(2**EE_AW)) begin
                ee_r[ecnt_r[EE_AW-1:0]] <= `PPP_ERASED;
            end
        end else if (wr_flash) begin
            if (half_s) flash_hi_r[faddr] <= dat_hi_r;
            else        flash_lo_r[faddr] <= dat_lo_r;
        end else if (wr_ee) begin
            ee_r[eaddr] <= dat_lo_r;
        end
    end

    // protection and fuse bits; fuses survive erase
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pb1_r   <= 1'b1;
            pb2_r   <= 1'b1;
            sdl_r   <= 1'b0;
            short_r <= 1'b1;
        end else if (erasing_r && ecnt_r[ERASE_W]) begin
            pb1_r <= 1'b1;
            pb2_r <= 1'b1;
        end else if (wr_lock) begin
            pb1_r <= pb1_r & dat_lo_r[`PPP_BIT_PB1_WR];
            pb2_r <= pb2_r & dat_lo_r[`PPP_BIT_PB2_WR];
        end else if (wr_fuse) begin
            sdl_r   <= dat_lo_r[`PPP_BIT_SDL_FUSE];
            short_r <= dat_lo_r[`PPP_BIT_SHORT];
        end
    end

    // self-timed byte write holds ready/busy low
    localparam int BUSY_W = $clog2(BUSY_CYC + 1);
    logic [BUSY_W-1:0] busy_r;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_r           <= '0;
            ready_busy_out_o <= 1'b1;
        end else if (wr_flash || wr_ee) begin
            busy_r           <= BUSY_W'(BUSY_CYC - 1);
            ready_busy_out_o <= 1'b0;
        end else if (busy_r != '0) begin
            busy_r <= busy_r - 1'b1;
        end else begin
            ready_busy_out_o <= 1'b1;
        end
    end

    // read mux; flash and eeprom reads blocked when both protection bits are programmed
    logic [7:0] rd_nxt;
    logic       verify_ok;
    assign verify_ok = pb1_r | pb2_r;
    always_comb begin
        rd_nxt = 8'h00;
        unique case (cmd_r)
            `PPP_CMD_RD_FLASH: if (verify_ok)
                rd_nxt = half_s ? flash_hi_r[faddr] : flash_lo_r[faddr];
            `PPP_CMD_RD_EE: if (verify_ok && !half_s)
                rd_nxt = ee_r[eaddr];
            `PPP_CMD_RD_LOCKF: if (half_s) begin
                rd_nxt = 8'hFF;
                rd_nxt[`PPP_BIT_PB1_RD]   = pb1_r;
                rd_nxt[`PPP_BIT_PB2_RD]   = pb2_r;
                rd_nxt[`PPP_BIT_SDL_FUSE] = sdl_r;
                rd_nxt[`PPP_BIT_SHORT]    = short_r;
            end
            `PPP_CMD_RD_SIG: if (!half_s) begin
                if (addr_lo_r == 8'h00)              rd_nxt = SIG0;
                else if (addr_lo_r == 8'h01)         rd_nxt = SIG1;
                else if (addr_lo_r == `PPP_SIG_LAST) rd_nxt = SIG2;
            end
            default: rd_nxt = 8'h00;
        endcase
    end

    // bus drive only while output enable is low
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o    <= rd_nxt;
            data_oe_o <= active && !oe_n_s;
        end
    end

    // status outputs registered
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_mode_o            <= 1'b0;
            serial_download_fuse_o <= 1'b0;
            short_startup_fuse_o   <= 1'b1;
        end else begin
            prog_mode_o            <= active;
            serial_download_fuse_o <= sdl_r;
            short_startup_fuse_o   <= short_r;
        end
    end

    // checks; a started byte write must show busy for at least two cycles
    sequence busy_hold_s;
        !ready_busy_out_o [*2];
    endsequence
    busy_time_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (wr_flash || wr_ee) |=> busy_hold_s) else $error("busy not held");
    bus_drive_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        data_oe_o |-> $past(!oe_n_s)) else $error("bus driven without enable");
    erase_quiet_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr_erase && ready_busy_out_o && busy_r == '0 |=> ready_busy_out_o)
        else $error("erase toggled ready");
    // watches ready and the fuse registers, so a broken gate on the write decode is caught
    lock_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !pb1_r && ready_busy_out_o |=> ready_busy_out_o && $stable({sdl_r, short_r}))
        else $error("write while protected");
    erase_release_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        erasing_r && ecnt_r[ERASE_W] |=> pb1_r && pb2_r) else $error("protection kept");
    cmd_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        active && xs_rise && lat.action == `PPP_ACT_CMD |=> cmd_r == $past(lat.data))
        else $error("command not latched");
    cmd_keep_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !xs_rise |=> $stable(cmd_r)) else $error("command changed");
    entry_refuse_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        hv_s && mode_r == PPP_LOCKED |=> !active) else $error("entered after refusal");
endmodule
`default_nettype wire

// File: tb/ppp_programmer.sv
// programmer model: drives the port's pins from task calls
`timescale 1ns/10ps
`default_nettype none
module ppp_programmer (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] bus_i,
    output logic            prog_voltage_o,
    output logic            strobe_o,
    output logic [1:0]      action_o,
    output logic            half_o,
    output logic            write_n_o,
    output logic            oe_n_o,
    output logic [7:0]      data_o
);
    // idle pins: no high voltage, strobe low, write and enable released
    initial begin
        prog_voltage_o = 1'b0;
        strobe_o = 1'b0;
        action_o = 2'b11;
        half_o = 1'b0;
        write_n_o = 1'b1;
        oe_n_o = 1'b1;
        data_o = 8'hFF;
    end

    // select low first, then raise high voltage; bad moves half-select with it
    task automatic enter(input logic bad);
        @(negedge core_clk_i);
        prog_voltage_o = 1'b0;
        half_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
        prog_voltage_o = 1'b1;
        half_o = bad;
        repeat (8) @(negedge core_clk_i);
        half_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
    endtask

    // one strobe pulse, long enough for the input synchronisers
    task automatic latch(input logic [1:0] act, input logic h, input logic [7:0] d);
        @(negedge core_clk_i);
        action_o = act;
        half_o = h;
        data_o = d;
        @(negedge core_clk_i);
        strobe_o = 1'b1;
        repeat (4) @(negedge core_clk_i);
        strobe_o = 1'b0;
        repeat (4) @(negedge core_clk_i);
    endtask

    // write pulse of n cycles; the caller picks erase or fuse width
    task automatic pulse(input logic h, input int n);
        @(negedge core_clk_i);
        half_o = h;
        repeat (2) @(negedge core_clk_i);
        write_n_o = 1'b0;
        repeat (n) @(negedge core_clk_i);
        write_n_o = 1'b1;
        repeat (2) @(negedge core_clk_i);
    endtask

    // release the bus by pulling enable low, then sample what the port drives
    task automatic read(input logic h, output logic [7:0] v);
        @(negedge core_clk_i);
        half_o = h;
        oe_n_o = 1'b0;
        repeat (8) @(negedge core_clk_i);
        v = bus_i;
        oe_n_o = 1'b1;
        repeat (6) @(negedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// File: tb/parallel_program_port_bench.sv
// self-checking bench for the parallel programming port
`timescale 1ns/10ps
`default_nettype none
`include "ppp_map.svh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module parallel_program_port_bench;
    import ppp_pkg::*;
    localparam int BUSY = 20;
    localparam int FUSE_W = 15;
    // erase width scaled down to keep the run short; the port does not time it
    localparam int ERASE_PW = 50;
    localparam logic [7:0] SIGS [3] = '{8'h6B, 8'hD2, 8'h47}; // arbitrary identity values
    logic       core_clk = 1'b0;
    logic       nrst;
    logic       vpp, stb, half, wr_n, oe_n, dut_oe, ready, prog_mode, sdl_fuse, short_fuse;
    logic [1:0] act;
    logic [7:0] drv, dut_data;
    wire  [7:0] bus;
    int         n_fail = 0;
    int         n_tests = 0;
    int         low_total = 0;
    int         lows;

    // released bus shows the inverse of the last driven value, never a stale copy
    assign bus = dut_oe ? dut_data : (oe_n ? drv : ~drv);

    always #50 core_clk = ~core_clk;

    // cycles spent busy, for pulse-length and no-activity checks
    always @(posedge core_clk) if (ready !== 1'b1) low_total <= low_total + 1;

    ppp_programmer u_ppp_programmer (.core_clk_i(core_clk), .bus_i(bus),
        .prog_voltage_o(vpp), .strobe_o(stb), .action_o(act), .half_o(half),
        .write_n_o(wr_n), .oe_n_o(oe_n), .data_o(drv));

    ppp_port #(.BUSY_CYC(BUSY), .SIG0(SIGS[0]), .SIG1(SIGS[1]), .SIG2(SIGS[2])) u_ppp_port (
        .core_clk_i(core_clk), .nrst_i(nrst), .prog_voltage_i(vpp),
        .crystal_strobe_pin_i(stb), .strobe_action_bit0_i(act[0]),
        .strobe_action_bit1_i(act[1]), .byte_half_select_i(half), .write_n_i(wr_n),
        .output_enable_n_i(oe_n), .data_i(bus), .data_o(dut_data), .data_oe_o(dut_oe),
        .ready_busy_out_o(ready), .prog_mode_o(prog_mode),
        .serial_download_fuse_o(sdl_fuse), .short_startup_fuse_o(short_fuse));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] c);
        u_ppp_programmer.latch(`PPP_ACT_CMD, 1'b0, c);
    endtask

    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b1, hi);
        u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b0, lo);
    endtask

    // bounded wait; the next write is only started once ready is back
    task automatic wait_rdy();
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 200) begin
            @(negedge core_clk);
            k++;
        end
        `CHECK(ready, 1'b1)
    endtask

    // latch a data byte, pulse write, report how many cycles were busy
    task automatic put(input logic h, input logic [7:0] d, input int w, output int n);
        int t0;
        u_ppp_programmer.latch(`PPP_ACT_DATA, h, d);
        t0 = low_total;
        u_ppp_programmer.pulse(h, w);
        repeat (8) @(negedge core_clk);
        wait_rdy();
        n = low_total - t0;
    endtask

    task automatic rd_chk(input logic h, input logic [7:0] exp);
        logic [7:0] v;
        u_ppp_programmer.read(h, v);
        `CHECK(v, exp)
        `CHECK(dut_oe, 1'b0)
    endtask

    // erase runs 2^12+1 cycles after the write falls and never shows busy
    task automatic erase();
        int t0;
        cmd(`PPP_CMD_ERASE);
        t0 = low_total;
        u_ppp_programmer.pulse(1'b0, ERASE_PW);
        repeat (4200) @(negedge core_clk);
        `CHECK(low_total - t0, 0)
    endtask

    initial begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        repeat (20) @(negedge core_clk);
        `CHECK({ready, prog_mode, sdl_fuse, short_fuse}, 4'h9)
        nrst = 1'b1;
        u_ppp_programmer.enter(1'b1);
        `CHECK(prog_mode, 1'b0)
        u_ppp_programmer.enter(1'b0);
        `CHECK(prog_mode, 1'b1)
        erase();
        // busy stands for exactly the self-timed count of cycles
        cmd(`PPP_CMD_WR_FLASH);
        addr(8'h0A, 8'h5C);
        put(1'b0, 8'h34, 4, lows);
        `CHECK(lows, BUSY)
        put(1'b1, 8'h12, 4, lows);
        `CHECK(lows, BUSY)
        // next word in the same page: only the low address is reloaded
        u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b0, 8'h5D);
        put(1'b0, 8'hC7, 4, lows);
        `CHECK(lows, BUSY)
        cmd(`PPP_CMD_RD_FLASH);
        // idle action carrying an erase byte must change nothing
        u_ppp_programmer.latch(2'b11, 1'b0, `PPP_CMD_ERASE);
        u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b0, 8'h5C);
        rd_chk(1'b0, 8'h34);
        rd_chk(1'b1, 8'h12);
        u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b0, 8'h5D);
        rd_chk(1'b0, 8'hC7);
        rd_chk(1'b1, 8'hFF);
        addr(8'h0B, 8'h5C);
        rd_chk(1'b0, 8'hFF);
        cmd(`PPP_CMD_WR_EE);
        addr(8'h01, 8'h23);
        put(1'b0, 8'h3E, 4, lows);
        `CHECK(lows, BUSY)
        cmd(`PPP_CMD_RD_EE);
        rd_chk(1'b0, 8'h3E);
        addr(8'h00, 8'h23);
        rd_chk(1'b0, 8'hFF);
        cmd(`PPP_CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            u_ppp_programmer.latch(`PPP_ACT_ADDR, 1'b0, 8'(i));
            rd_chk(1'b0, SIGS[i]);
        end
        cmd(`PPP_CMD_WR_FUSE);
        put(1'b0, 8'hFE, FUSE_W, lows);
        `CHECK(lows, 0)
        `CHECK({sdl_fuse, short_fuse}, 2'h2)
        cmd(`PPP_CMD_RD_LOCKF);
        rd_chk(1'b1, 8'hFE);
        cmd(`PPP_CMD_WR_LOCK);
        put(1'b0, 8'hFD, 4, lows);
        cmd(`PPP_CMD_RD_LOCKF);
        rd_chk(1'b1, 8'h7E);
        // first protection bit set: flash, eeprom and fuse writes must be dropped
        cmd(`PPP_CMD_WR_FLASH);
        addr(8'h0A, 8'h60);
        put(1'b0, 8'h77, 4, lows);
        `CHECK(lows, 0)
        cmd(`PPP_CMD_RD_FLASH);
        rd_chk(1'b0, 8'hFF);
        cmd(`PPP_CMD_WR_EE);
        put(1'b0, 8'h55, 4, lows);
        `CHECK(lows, 0)
        cmd(`PPP_CMD_WR_FUSE);
        put(1'b0, 8'hDF, FUSE_W, lows);
        `CHECK({sdl_fuse, short_fuse}, 2'h2)
        cmd(`PPP_CMD_WR_LOCK);
        put(1'b0, 8'hF9, 4, lows);
        cmd(`PPP_CMD_RD_LOCKF);
        rd_chk(1'b1, 8'h3E);
        cmd(`PPP_CMD_RD_FLASH);
        addr(8'h0A, 8'h5C);
        rd_chk(1'b0, 8'h00);
        erase();
        cmd(`PPP_CMD_RD_LOCKF);
        rd_chk(1'b1, 8'hFE);
        cmd(`PPP_CMD_RD_FLASH);
        rd_chk(1'b0, 8'hFF);
        cmd(`PPP_CMD_RD_EE);
        addr(8'h01, 8'h23);
        rd_chk(1'b0, 8'hFF);
        give_verdict();
    end
endmodule
`default_nettype wire
